// ---- evu_defs.svh ----
// register offsets, field positions, reset values and timing counts of the event unit
`ifndef EVU_DEFS_SVH
`define EVU_DEFS_SVH
`define EVU_OFF_CTRL 12'h000
`define EVU_OFF_STATUS 12'h004
`define EVU_OFF_BP_INDEX 12'h008
`define EVU_OFF_BP_ENTRY 12'h00C
`define EVU_OFF_ONCHIP 12'h010
`define EVU_OFF_FILTER 12'h014
`define EVU_CH_REGION 3'h1
`define EVU_CW_LO 3'h0
`define EVU_CW_HI 3'h1
`define EVU_CW_DATA 3'h2
`define EVU_CW_MASK 3'h3
`define EVU_CW_COND 3'h4
`define EVU_CW_ACT 3'h5
`define EVU_CW_CNT 3'h6
`define EVU_CTRL_EN 0
`define EVU_CTRL_LAST_LSB 1
`define EVU_CTRL_SEQ_EN 4
`define EVU_ST_HALT 0
`define EVU_ST_STAGE_LSB 1
`define EVU_ST_TRACE 4
`define EVU_ST_TIMER 5
`define EVU_ST_CAUSE_LSB 6
`define EVU_BP_VALID 31
`define EVU_COND_EN 0
`define EVU_COND_RANGE 1
`define EVU_COND_OUT 2
`define EVU_COND_DIR_LSB 3
`define EVU_COND_CLS_EN 5
`define EVU_COND_CLS_LSB 6
`define EVU_COND_AREA_EN 9
`define EVU_COND_AREA_LSB 10
`define EVU_COND_PRB_EN 13
`define EVU_COND_PRB_LSB 14
`define EVU_COND_PMSK_LSB 18
`define EVU_ACT_BRK 0
`define EVU_ACT_TRS 1
`define EVU_ACT_TRP 2
`define EVU_ACT_TMS 3
`define EVU_ACT_TMP 4
`define EVU_ACT_CNT_LSB 8
`define EVU_ACT_DLY_LSB 16
`define EVU_FILT_SUP_LSB 0
`define EVU_FILT_ACC_LSB 8
`define EVU_CTRL_RST 32'h00000001
`define EVU_FILT_RST 32'h00000000
`define EVU_ONCHIP_RST 32'h00000000
`define EVU_CH_RST 32'h00000000
`define EVU_PIPE_LAT 3
`endif

// ---- evu_pkg.sv ----
// types shared by the event unit and its channels
package evu_pkg;
  typedef enum logic [2:0] {
    prefetch_cycle_class, data_cycle_class, refresh_cycle_class,
    dma_cycle_class, transfer_ctrl_cycle_class, other_cycle_class
  } bus_class_t;
  typedef enum logic [2:0] {
    rom_area, ram_area, io_wide_area, io_narrow_area,
    external_wide_area, external_narrow_area, transfer_ctrl_ram_area
  } area_t;
  typedef struct packed {
    logic valid;
    logic [23:0] addr;
    logic write;
    logic [15:0] data;
    bus_class_t cls;
    area_t area;
    logic [3:0] probe;
  } bus_sample_t;
endpackage

// ---- chan_if.sv ----
// configuration, bus sample and results between the unit and one channel
`timescale 1ns/100ps
`default_nettype none
interface chan_if;
  import evu_pkg::*;
  logic [31:0] lo, hi, dat, msk, cond, act;
  bus_sample_t smp;
  logic arm;
  logic match;
  logic hit;
  logic [7:0] count;
  modport ctrl (output lo, hi, dat, msk, cond, act, smp, arm, input match, hit, count);
  modport chan (input lo, hi, dat, msk, cond, act, smp, arm, output match, hit, count);
endinterface
`default_nettype wire

// ---- event_channel.sv ----
// one event or range channel: condition match, occurrence count, delay
`timescale 1ns/100ps
`default_nettype none
`include "evu_defs.svh"
module event_channel import evu_pkg::*; #(
  parameter bit HAS_COUNT = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  chan_if.chan port
);
  logic in_rng, addr_ok, dir_ok, data_ok, cls_ok, area_ok, prb_ok, fire;
  logic [7:0] target, cnt_reg;
  logic [15:0] dly_reg, delay;
  logic dly_run_reg, hit_reg;
  logic [1:0] dir;
  logic [3:0] pval, pmsk;
  assign dir = port.cond[`EVU_COND_DIR_LSB +: 2];
  assign pval = port.cond[`EVU_COND_PRB_LSB +: 4];
  assign pmsk = port.cond[`EVU_COND_PMSK_LSB +: 4];
  assign delay = port.act[`EVU_ACT_DLY_LSB +: 16];
  always_comb begin
    in_rng = port.smp.addr >= port.lo[23:0] && port.smp.addr <= port.hi[23:0];
    if (port.cond[`EVU_COND_RANGE]) begin
      addr_ok = port.cond[`EVU_COND_OUT] ? !in_rng : in_rng;
    end else begin
      addr_ok = port.smp.addr == port.lo[23:0];
    end
    dir_ok = (dir == 2'h1) ? !port.smp.write : (dir == 2'h2) ? port.smp.write : 1'b1;
    data_ok = ((port.smp.data ^ port.dat[15:0]) & port.msk[15:0]) == 16'h0000;
    cls_ok = !port.cond[`EVU_COND_CLS_EN] ||
      port.smp.cls == bus_class_t'(port.cond[`EVU_COND_CLS_LSB +: 3]);
    area_ok = !port.cond[`EVU_COND_AREA_EN] ||
      port.smp.area == area_t'(port.cond[`EVU_COND_AREA_LSB +: 3]);
    prb_ok = !port.cond[`EVU_COND_PRB_EN] || ((port.smp.probe ^ pval) & pmsk) == 4'h0;
  end
  assign port.match = port.smp.valid && port.cond[`EVU_COND_EN] && addr_ok && dir_ok &&
    data_ok && cls_ok && area_ok && prb_ok;
  assign target = HAS_COUNT ? port.act[`EVU_ACT_CNT_LSB +: 8] : 8'h01;
  assign fire = port.match && port.arm && (cnt_reg + 8'h01 >= target);
  always_ff @(posedge clk) begin
    if (rst || !port.cond[`EVU_COND_EN]) begin
      cnt_reg <= '0;
    end else if (port.match && port.arm) begin
      cnt_reg <= fire ? 8'h00 : cnt_reg + 8'h01;
    end
  end
  always_ff @(posedge clk) begin
    if (rst || !port.cond[`EVU_COND_EN]) begin
      hit_reg <= 1'b0;
      dly_run_reg <= 1'b0;
      dly_reg <= '0;
    end else begin
      hit_reg <= 1'b0;
      if (dly_run_reg) begin
        dly_reg <= dly_reg - 16'h0001;
        if (dly_reg == 16'h0001) begin
          hit_reg <= 1'b1;
          dly_run_reg <= 1'b0;
        end
      end else if (fire) begin
        if (delay == 16'h0000) begin
          hit_reg <= 1'b1;
        end else begin
          dly_run_reg <= 1'b1;
          dly_reg <= delay;
        end
      end
    end
  end
  assign port.hit = hit_reg;
  assign port.count = cnt_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_fire_now;
    fire && !dly_run_reg && delay == 16'h0000 && port.cond[`EVU_COND_EN];
  endsequence
  chk_count_reach: assert property (s_fire_now |=> hit_reg)
    else $error("count reached but no hit");
  chk_hit_cause: assert property (hit_reg |-> $past(fire || (dly_run_reg && dly_reg == 16'h0001)))
    else $error("hit without cause");
  chk_range_nocount: assert property (!HAS_COUNT |-> cnt_reg == 8'h00)
    else $error("range channel counted");
endmodule // event_channel
`default_nettype wire

// ---- bus_event_detection_unit.sv ----
// event unit top: apb registers, software breakpoints, channels, sequencing, actions
// Function
// - fetch outside ROM area at breakpoint address halts; 256 entries
// - single ROM breakpoint halts after instruction
// - twelve event points: event plus range channels
// - event channel matches address, data, class, probes
// - range channels: no count, no sequencing
// - up to eight chained stages, last acts
// - events halt, start/stop timer and trace
// - actions follow match by fixed pipeline latency plus the channel's programmed delay
// - target supplies bus class and area codes
// - bus class suppresses trace and filters counting
// - software breakpoint compares fetch address only
`timescale 1ns/100ps
`default_nettype none
`include "evu_defs.svh"
module bus_event_detection_unit import evu_pkg::*; #(
  parameter int N_EVENT = 8,
  parameter int N_RANGE = 4,
  parameter int N_SWBP = 256
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bus_valid,
  input wire logic [23:0] bus_addr,
  input wire logic bus_write,
  input wire logic [15:0] bus_data,
  input wire logic [2:0] bus_class,
  input wire logic [2:0] bus_area,
  input wire logic [3:0] probe_pin,
  output logic break_req,
  output logic halted,
  output logic trace_active,
  output logic trace_capture,
  output logic timer_active,
  output logic access_count
);
  localparam int NCH = N_EVENT + N_RANGE;
  generate
    if (N_EVENT < 1 || N_EVENT > 8 || N_RANGE < 1 || N_RANGE > 8 || N_SWBP < 1 ||
      N_SWBP > 256) begin : g_bad
      $error("unsupported channel or breakpoint count");
    end
  endgenerate

  // probe pins are asynchronous
  logic [3:0] probe_meta_reg, probe_sync_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      probe_meta_reg <= 4'h0;
      probe_sync_reg <= 4'h0;
    end else begin
      probe_meta_reg <= probe_pin;
      probe_sync_reg <= probe_meta_reg;
    end
  end

  // capture stage of the monitored bus
  bus_sample_t smp_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      smp_reg <= '0;
    end else begin
      smp_reg.valid <= bus_valid;
      smp_reg.addr <= bus_addr;
      smp_reg.write <= bus_write;
      smp_reg.data <= bus_data;
      smp_reg.cls <= bus_class_t'(bus_class);
      smp_reg.area <= area_t'(bus_area);
      smp_reg.probe <= probe_sync_reg;
    end
  end

  // apb decode, zero wait states
  logic wr_en, ch_sel, glob_wr, st_clr;
  logic [3:0] ch_idx;
  logic [2:0] cw;
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign ch_idx = paddr[8:5];
  assign cw = paddr[4:2];
  assign ch_sel = paddr[11:9] == `EVU_CH_REGION && 32'(ch_idx) < NCH && paddr[1:0] == 2'h0;
  assign glob_wr = wr_en && !ch_sel;
  assign st_clr = glob_wr && paddr == `EVU_OFF_STATUS && pwdata[`EVU_ST_HALT];

  logic [31:0] ctrl_reg, filt_reg, onchip_reg;
  logic [7:0] bp_index_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= `EVU_CTRL_RST;
      filt_reg <= `EVU_FILT_RST;
      onchip_reg <= `EVU_ONCHIP_RST;
      bp_index_reg <= 8'h00;
    end else if (glob_wr) begin
      if (paddr == `EVU_OFF_CTRL) ctrl_reg <= pwdata;
      if (paddr == `EVU_OFF_FILTER) filt_reg <= pwdata;
      if (paddr == `EVU_OFF_ONCHIP) onchip_reg <= pwdata;
      if (paddr == `EVU_OFF_BP_INDEX) bp_index_reg <= pwdata[7:0];
    end
  end

  // software breakpoint table
  logic [N_SWBP-1:0] bp_valid_reg;
  logic [23:0] bp_addr_mem [N_SWBP];
  logic bp_wr, bp_ok;
  assign bp_ok = 32'(bp_index_reg) < N_SWBP;
  assign bp_wr = glob_wr && paddr == `EVU_OFF_BP_ENTRY && bp_ok;
  always_ff @(posedge clk) begin
    if (rst) begin
      bp_valid_reg <= '0;
    end else if (bp_wr) begin
      bp_valid_reg[bp_index_reg] <= pwdata[`EVU_BP_VALID];
    end
  end
  always_ff @(posedge clk) begin
    if (bp_wr) begin
      bp_addr_mem[bp_index_reg] <= pwdata[23:0];
    end
  end

  logic fetch, sw_hit, sw_break, oc_match, oc_break;
  assign fetch = smp_reg.valid && smp_reg.cls == prefetch_cycle_class;
  always_comb begin
    sw_hit = 1'b0;
    for (int i = 0; i < N_SWBP; i++) begin
      if (bp_valid_reg[i] && bp_addr_mem[i] == smp_reg.addr) sw_hit = 1'b1;
    end
  end
  assign sw_break = fetch && smp_reg.area != rom_area && sw_hit;
  assign oc_match = fetch && smp_reg.area == rom_area && onchip_reg[`EVU_BP_VALID] &&
    onchip_reg[23:0] == smp_reg.addr;
  logic oc_pend_reg, sw_brk_reg, oc_brk_reg;
  assign oc_break = oc_pend_reg && fetch;
  always_ff @(posedge clk) begin
    if (rst) begin
      oc_pend_reg <= 1'b0;
      sw_brk_reg <= 1'b0;
      oc_brk_reg <= 1'b0;
    end else begin
      oc_pend_reg <= oc_match || (oc_pend_reg && !fetch);
      sw_brk_reg <= sw_break;
      oc_brk_reg <= oc_break;
    end
  end

  // channel configuration words
  logic [31:0] lo_reg [NCH];
  logic [31:0] hi_reg [NCH];
  logic [31:0] dat_reg [NCH];
  logic [31:0] msk_reg [NCH];
  logic [31:0] cond_reg [NCH];
  logic [31:0] act_reg [NCH];
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NCH; i++) begin
        lo_reg[i] <= `EVU_CH_RST;
        hi_reg[i] <= `EVU_CH_RST;
        dat_reg[i] <= `EVU_CH_RST;
        msk_reg[i] <= `EVU_CH_RST;
        cond_reg[i] <= `EVU_CH_RST;
        act_reg[i] <= `EVU_CH_RST;
      end
    end else if (wr_en && ch_sel) begin
      if (cw == `EVU_CW_LO) lo_reg[ch_idx] <= pwdata;
      if (cw == `EVU_CW_HI) hi_reg[ch_idx] <= pwdata;
      if (cw == `EVU_CW_DATA) dat_reg[ch_idx] <= pwdata;
      if (cw == `EVU_CW_MASK) msk_reg[ch_idx] <= pwdata;
      if (cw == `EVU_CW_COND) cond_reg[ch_idx] <= pwdata;
      if (cw == `EVU_CW_ACT) act_reg[ch_idx] <= pwdata;
    end
  end

  // sequencing over the first event channels
  logic seq_en;
  logic [2:0] seq_last, last_raw, stage_reg;
  logic [NCH-1:0] hit, match, arm, act_ok;
  logic [7:0] cnt_v [NCH];
  assign seq_en = ctrl_reg[`EVU_CTRL_SEQ_EN];
  assign last_raw = ctrl_reg[`EVU_CTRL_LAST_LSB +: 3];
  assign seq_last = (32'(last_raw) < N_EVENT) ? last_raw : 3'(N_EVENT - 1);

  chan_if cif [NCH] ();
  generate
    for (genvar g = 0; g < NCH; g++) begin : g_ch
      localparam bit IS_EVENT = g < N_EVENT;
      logic in_seq;
      assign in_seq = IS_EVENT && seq_en && 3'(g) <= seq_last;
      assign arm[g] = !in_seq || stage_reg == 3'(g);
      assign act_ok[g] = !in_seq || 3'(g) == seq_last;
      assign cif[g].lo = lo_reg[g];
      assign cif[g].hi = hi_reg[g];
      assign cif[g].dat = dat_reg[g];
      assign cif[g].msk = msk_reg[g];
      assign cif[g].cond = cond_reg[g];
      assign cif[g].act = act_reg[g];
      assign cif[g].smp = smp_reg;
      assign cif[g].arm = arm[g];
      assign hit[g] = cif[g].hit;
      assign match[g] = cif[g].match;
      assign cnt_v[g] = cif[g].count;
      event_channel #(.HAS_COUNT(IS_EVENT)) u_ch (
        .clk(clk),
        .rst(rst),
        .port(cif[g])
      );
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst || (glob_wr && paddr == `EVU_OFF_CTRL)) begin
      stage_reg <= 3'h0;
    end else if (seq_en && hit[stage_reg]) begin
      stage_reg <= (stage_reg == seq_last) ? 3'h0 : stage_reg + 3'h1;
    end
  end

  // action stage
  logic en, brk_v, trs_v, trp_v, tms_v, tmp_v, any_brk;
  logic [5:0] supp_bits, acc_bits;
  logic [2:0] cause_reg;
  logic halt_reg, trace_reg, timer_reg, brk_reg, cap_reg, acc_reg;
  assign en = ctrl_reg[`EVU_CTRL_EN];
  always_comb begin
    brk_v = 1'b0;
    trs_v = 1'b0;
    trp_v = 1'b0;
    tms_v = 1'b0;
    tmp_v = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      if (hit[i] && act_ok[i]) begin
        brk_v |= act_reg[i][`EVU_ACT_BRK];
        trs_v |= act_reg[i][`EVU_ACT_TRS];
        trp_v |= act_reg[i][`EVU_ACT_TRP];
        tms_v |= act_reg[i][`EVU_ACT_TMS];
        tmp_v |= act_reg[i][`EVU_ACT_TMP];
      end
    end
  end
  assign any_brk = brk_v || sw_brk_reg || oc_brk_reg;
  assign supp_bits = filt_reg[`EVU_FILT_SUP_LSB +: 6];
  assign acc_bits = filt_reg[`EVU_FILT_ACC_LSB +: 6];
  always_ff @(posedge clk) begin
    if (rst) begin
      brk_reg <= 1'b0;
      halt_reg <= 1'b0;
      cause_reg <= 3'h0;
    end else begin
      brk_reg <= en && any_brk;
      halt_reg <= (en && any_brk) || (halt_reg && !st_clr);
      cause_reg <= (en && any_brk) ? (cause_reg | {brk_v, oc_brk_reg, sw_brk_reg}) :
        (st_clr ? 3'h0 : cause_reg);
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      trace_reg <= 1'b0;
      timer_reg <= 1'b0;
    end else if (en) begin
      trace_reg <= trs_v || (trace_reg && !trp_v);
      timer_reg <= tms_v || (timer_reg && !tmp_v);
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      cap_reg <= 1'b0;
      acc_reg <= 1'b0;
    end else begin
      cap_reg <= trace_reg && smp_reg.valid && !supp_bits[smp_reg.cls];
      acc_reg <= smp_reg.valid && acc_bits[smp_reg.cls] && |match[NCH-1:N_EVENT];
    end
  end
  assign break_req = brk_reg;
  assign halted = halt_reg;
  assign trace_active = trace_reg;
  assign timer_active = timer_reg;
  assign trace_capture = cap_reg;
  assign access_count = acc_reg;

  // apb read and error answer
  always_comb begin
    prdata = 32'h00000000;
    pslverr = 1'b0;
    if (ch_sel) begin
      case (cw)
        `EVU_CW_LO: prdata = lo_reg[ch_idx];
        `EVU_CW_HI: prdata = hi_reg[ch_idx];
        `EVU_CW_DATA: prdata = dat_reg[ch_idx];
        `EVU_CW_MASK: prdata = msk_reg[ch_idx];
        `EVU_CW_COND: prdata = cond_reg[ch_idx];
        `EVU_CW_ACT: prdata = act_reg[ch_idx];
        `EVU_CW_CNT: prdata = {24'h000000, cnt_v[ch_idx]};
        default: pslverr = psel && penable;
      endcase
    end else begin
      case (paddr)
        `EVU_OFF_CTRL: prdata = ctrl_reg;
        `EVU_OFF_STATUS: prdata = {23'h000000, cause_reg, timer_reg, trace_reg, stage_reg, halt_reg};
        `EVU_OFF_BP_INDEX: prdata = {24'h000000, bp_index_reg};
        `EVU_OFF_BP_ENTRY: prdata = bp_ok ?
          {bp_valid_reg[bp_index_reg], 7'h00, bp_addr_mem[bp_index_reg]} : 32'h00000000;
        `EVU_OFF_ONCHIP: prdata = onchip_reg;
        `EVU_OFF_FILTER: prdata = filt_reg;
        default: pslverr = psel && penable;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_sw_fetch;
    sw_break && en;
  endsequence
  sequence s_break_out;
    ##2 break_req;
  endsequence
  chk_swbp_break: assert property (s_sw_fetch |-> s_break_out)
    else $error("software breakpoint did not halt");
  chk_onchip_after: assert property ($rose(oc_pend_reg) |-> !oc_brk_reg)
    else $error("rom breakpoint halted before execution");
  chk_onchip_next: assert property (oc_pend_reg && fetch |=> oc_brk_reg)
    else $error("rom breakpoint not taken on next fetch");
  chk_seq_advance: assert property (seq_en && hit[stage_reg] && stage_reg != seq_last &&
    !(glob_wr && paddr == `EVU_OFF_CTRL) |=> stage_reg == $past(stage_reg) + 3'h1)
    else $error("sequence stage did not advance");
  chk_trace_start: assert property (en && trs_v |=> trace_reg)
    else $error("trace start ignored");
  chk_pipe_latency: assert property (break_req |-> $past(en && any_brk))
    else $error("break without cause one cycle earlier");
  chk_trace_suppress: assert property (trace_capture |-> $past(!supp_bits[smp_reg.cls]))
    else $error("suppressed cycle captured");
  chk_swbp_fetch: assert property (sw_brk_reg |-> $past(fetch))
    else $error("software breakpoint on non fetch cycle");
endmodule // bus_event_detection_unit
`default_nettype wire

// ---- target_bus_model.sv ----
// behavioural model of the monitored target bus
`timescale 1ns/100ps
`default_nettype none
module target_bus_model import evu_pkg::*; (
  input wire logic clk,
  output logic bus_valid,
  output logic [23:0] bus_addr,
  output logic bus_write,
  output logic [15:0] bus_data,
  output logic [2:0] bus_class,
  output logic [2:0] bus_area,
  output logic [3:0] probe_pin
);
  initial begin
    bus_valid = 1'b0;
    bus_addr = 24'h000000;
    bus_write = 1'b0;
    bus_data = 16'h0000;
    bus_class = 3'h5;
    bus_area = 3'h1;
    probe_pin = 4'h0;
  end
  // one monitored cycle, then valid drops and address, data, class and probes change
  task automatic cycle(input logic [23:0] a, input logic w, input logic [15:0] d,
                       input bus_class_t c, input area_t ar);
    @(posedge clk);
    bus_valid <= 1'b1;
    bus_addr <= a;
    bus_write <= w;
    bus_data <= d;
    bus_class <= c;
    bus_area <= ar;
    probe_pin <= 4'($urandom);
    @(posedge clk);
    bus_valid <= 1'b0;
    bus_addr <= ~a;
    bus_data <= ~d;
    bus_class <= ~c;
    probe_pin <= ~probe_pin;
  endtask
endmodule // target_bus_model
`default_nettype wire

// ---- tb_top.sv ----
// self-checking testbench of the bus event detection unit
`timescale 1ns/100ps
`default_nettype none
`include "evu_defs.svh"
module tb_top import evu_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  logic bus_valid, bus_write;
  logic [23:0] bus_addr, a, b;
  logic [15:0] bus_data;
  logic [2:0] bus_class, bus_area;
  logic [3:0] probe_pin;
  logic break_req, halted, trace_active, trace_capture, timer_active, access_count;
  int miscompares = 0;
  int tests_run = 0;
  bus_class_t c;
  always #20 clk = ~clk;
  bus_event_detection_unit uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_valid(bus_valid), .bus_addr(bus_addr), .bus_write(bus_write),
    .bus_data(bus_data), .bus_class(bus_class), .bus_area(bus_area), .probe_pin(probe_pin),
    .break_req(break_req), .halted(halted), .trace_active(trace_active),
    .trace_capture(trace_capture), .timer_active(timer_active), .access_count(access_count));
  target_bus_model tgt (.clk(clk), .bus_valid(bus_valid), .bus_addr(bus_addr),
    .bus_write(bus_write), .bus_data(bus_data), .bus_class(bus_class),
    .bus_area(bus_area), .probe_pin(probe_pin));
  task automatic wrap_up;
    if (miscompares == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t output %b expected %b", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic chw(input int n, input logic [2:0] w, input logic [31:0] d);
    apb(1'b1, 12'h200 + 12'(n * 32) + 12'(w * 4), d);
  endtask
  function automatic logic in_range(input logic [23:0] x, input logic [23:0] lo,
                                    input logic [23:0] hi);
    return x >= lo && x <= hi;
  endfunction
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h0189));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `EVU_OFF_CTRL, 32'h0);
    chk(rd, `EVU_CTRL_RST);
    apb(1'b0, `EVU_OFF_FILTER, 32'h0);
    chk(rd, `EVU_FILT_RST);
    apb(1'b0, `EVU_OFF_ONCHIP, 32'h0);
    chk(rd, `EVU_ONCHIP_RST);
    apb(1'b0, 12'h1F0, 32'h0);
    chk({31'h0, err}, 32'h1);
    // software table: index 255 and random ones, fetch only
    for (int i = 0; i < 3; i++) begin
      a = 24'($urandom) & 24'hFFFFFE;
      apb(1'b1, `EVU_OFF_BP_INDEX, (i == 0) ? 32'hFF : $urandom_range(254, 0));
      apb(1'b1, `EVU_OFF_BP_ENTRY, {8'h80, a});
      apb(1'b0, `EVU_OFF_BP_ENTRY, 32'h0);
      chk(rd, {8'h80, a});
      tgt.cycle(a, 1'b0, 16'($urandom), data_cycle_class, ram_area);
      tick(5);
      chk_bit(halted, 1'b0);
      tgt.cycle(a, 1'b0, 16'($urandom), prefetch_cycle_class, ram_area);
      tick(1);
      chk_bit(break_req, 1'b0);
      tick(1);
      chk_bit(break_req, 1'b1);
      chk_bit(halted, 1'b1);
      apb(1'b0, `EVU_OFF_STATUS, 32'h0);
      chk(rd, (32'h1 << `EVU_ST_CAUSE_LSB) | (32'h1 << `EVU_ST_HALT));
      apb(1'b1, `EVU_OFF_STATUS, 32'h1);
      tick(1);
      chk_bit(halted, 1'b0);
    end
    // rom area breakpoint stops after the instruction
    do_reset();
    a = 24'($urandom) & 24'h00FFFE;
    apb(1'b1, `EVU_OFF_ONCHIP, {8'h80, a});
    tgt.cycle(a, 1'b0, 16'h0000, prefetch_cycle_class, rom_area);
    tick(6);
    chk_bit(halted, 1'b0);
    tgt.cycle(a + 24'h2, 1'b0, 16'h0000, prefetch_cycle_class, rom_area);
    tick(4);
    chk_bit(halted, 1'b1);
    // counted read event with masked data
    do_reset();
    a = 24'($urandom);
    chw(0, `EVU_CW_LO, {8'h00, a});
    chw(0, `EVU_CW_DATA, 32'h5A5A);
    chw(0, `EVU_CW_MASK, 32'hFFFF);
    chw(0, `EVU_CW_COND, 32'h9);
    chw(0, `EVU_CW_ACT, 32'h301);
    for (int i = 0; i < 4; i++)
      tgt.cycle(a, i == 1, (i == 2) ? 16'hA5A5 : 16'h5A5A, data_cycle_class, ram_area);
    tick(5);
    chk_bit(halted, 1'b0);
    tgt.cycle(a, 1'b0, 16'h5A5A, data_cycle_class, ram_area);
    tick(4);
    chk_bit(halted, 1'b1);
    // trace and timer start/stop, suppression, range access count
    do_reset();
    a = 24'h001000;
    b = 24'h002000;
    apb(1'b1, `EVU_OFF_FILTER, 32'h204);
    chw(1, `EVU_CW_LO, {8'h00, a});
    chw(1, `EVU_CW_COND, 32'h1);
    chw(1, `EVU_CW_ACT, 32'hA);
    chw(2, `EVU_CW_LO, {8'h00, b});
    chw(2, `EVU_CW_COND, 32'h1);
    chw(2, `EVU_CW_ACT, 32'h14);
    chw(8, `EVU_CW_LO, 32'h3000);
    chw(8, `EVU_CW_HI, 32'h3010);
    chw(8, `EVU_CW_COND, 32'h3);
    tgt.cycle(a, 1'b0, 16'h0, data_cycle_class, ram_area);
    tick(4);
    chk_bit(trace_active, 1'b1);
    chk_bit(timer_active, 1'b1);
    tgt.cycle(24'h000500, 1'b0, 16'h0, data_cycle_class, ram_area);
    tick(1);
    chk_bit(trace_capture, 1'b1);
    tgt.cycle(24'h000500, 1'b0, 16'h0, refresh_cycle_class, ram_area);
    tick(1);
    chk_bit(trace_capture, 1'b0);
    for (int i = 0; i < 8; i++) begin
      a = 24'h002FF8 + 24'($urandom_range(32, 0));
      c = ($urandom & 1) ? data_cycle_class : dma_cycle_class;
      tgt.cycle(a, 1'($urandom), 16'($urandom), c, ram_area);
      tick(1);
      chk_bit(access_count, in_range(a, 24'h3000, 24'h3010) && c == data_cycle_class);
    end
    tgt.cycle(b, 1'b0, 16'h0, data_cycle_class, ram_area);
    tick(4);
    chk_bit(trace_active, 1'b0);
    chk_bit(timer_active, 1'b0);
    // two-stage sequence, only the last stage acts
    do_reset();
    a = 24'h004000;
    b = 24'h004100;
    chw(0, `EVU_CW_LO, {8'h00, a});
    chw(0, `EVU_CW_COND, 32'h1);
    chw(0, `EVU_CW_ACT, 32'h1);
    chw(1, `EVU_CW_LO, {8'h00, b});
    chw(1, `EVU_CW_COND, 32'h1);
    chw(1, `EVU_CW_ACT, 32'h1);
    apb(1'b1, `EVU_OFF_CTRL, 32'h13);
    tgt.cycle(b, 1'b0, 16'h0, data_cycle_class, ram_area);
    tick(5);
    chk_bit(halted, 1'b0);
    tgt.cycle(a, 1'b0, 16'h0, data_cycle_class, ram_area);
    tick(5);
    chk_bit(halted, 1'b0);
    tgt.cycle(b, 1'b0, 16'h0, data_cycle_class, ram_area);
    tick(4);
    chk_bit(halted, 1'b1);
    // unit disabled: a valid breakpoint does not halt
    do_reset();
    apb(1'b1, `EVU_OFF_CTRL, 32'h0);
    apb(1'b1, `EVU_OFF_BP_INDEX, 32'h0);
    apb(1'b1, `EVU_OFF_BP_ENTRY, 32'h80000100);
    tgt.cycle(24'h000100, 1'b0, 16'h0, prefetch_cycle_class, ram_area);
    tick(5);
    chk_bit(halted, 1'b0);
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
